// ==== rtl/typec_attach_pkg.sv ====
// Purpose: shared constants and carrier types for the attach decoder
// Assumes: one core clock, asynchronous active-low reset
// Notes: attach_cfg_t selects the receptacle configuration
package typec_attach_pkg;

  localparam int unsigned ATTACH_W = 3;
  localparam int unsigned PHY_LANES = 2;
  localparam int unsigned FILT_CYCLES = 2;

  typedef enum logic [1:0] {
    CFG_EXT_MUX = 2'b00,
    CFG_MODE_ONE = 2'b01,
    CFG_MODE_TWO = 2'b10
  } attach_cfg_t;

  typedef struct packed {
    logic [ATTACH_W-1:0] port1_attach_in;
    logic port1_orientation_in;
    logic mux_attach_sel_a;
    logic mux_attach_sel_b;
  } attach_pins_t;

  typedef struct packed {
    logic phy_clk_en;
    logic [PHY_LANES-1:0] phy_lane_en;
    logic attached;
    logic flipped;
  } phy_ctl_t;

  localparam phy_ctl_t PHY_CTL_RESET = '0;

endpackage : typec_attach_pkg

// ==== rtl/attach_filter.sv ====
// Purpose: holds an input level until it is stable for a number of cycles
// Assumes: input synchronous to the core clock
// Notes: one instance filters every raw attach pin group together as one vector
`timescale 1ns/1ps
`default_nettype none
module attach_filter #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned STABLE = 2
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_level,
  output logic [WIDTH-1:0] o_level
);

  logic [WIDTH-1:0] held;
  logic [WIDTH-1:0] cand;
  logic [7:0] cnt;
  logic [WIDTH-1:0] next_held;
  logic [WIDTH-1:0] next_cand;
  logic [7:0] next_cnt;

  always_comb begin
    next_held = held;
    next_cand = i_level;
    next_cnt = 8'h00;
    if (i_level == cand) begin
      if (cnt >= 8'(STABLE - 1)) begin
        next_held = cand;
        next_cnt = cnt;
      end else begin
        next_cnt = cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      held <= '0;
      cand <= '0;
      cnt <= 8'h00;
    end else begin
      held <= next_held;
      cand <= next_cand;
      cnt <= next_cnt;
    end
  end

  assign o_level = held;

endmodule : attach_filter
`default_nettype wire

// ==== rtl/typec_attach_phy_control.sv ====
// Purpose: decode Type-C attach and orientation into PHY clock/lane enables
// Assumes: pins synchronous to i_core_clk; reset held while in standby
// Notes: straps are caught on the first clock after reset release
`timescale 1ns/1ps
`default_nettype none
module typec_attach_phy_control #(
  parameter int unsigned FILT = typec_attach_pkg::FILT_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_external_mux_sel,
  input wire logic i_internal_mux_mode_sel,
  input wire logic i_attach_polarity_strap,
  input wire typec_attach_pkg::attach_pins_t i_pins,
  output logic o_phy_clk_en,
  output logic [typec_attach_pkg::PHY_LANES-1:0] o_phy_lane_en,
  output logic o_attached,
  output logic o_flipped,
  output logic [1:0] o_cfg
);

  typec_attach_pkg::attach_cfg_t cfg;
  typec_attach_pkg::attach_cfg_t next_cfg;
  logic pol;
  logic next_pol;
  logic strap_done;
  logic next_strap_done;
  typec_attach_pkg::phy_ctl_t ctl;
  typec_attach_pkg::phy_ctl_t next_ctl;

  // polarity applied to every attach-type input before filtering
  logic [typec_attach_pkg::ATTACH_W+2:0] raw;
  logic [typec_attach_pkg::ATTACH_W+2:0] flt;

  // active-high when strap is low; inverted when strap is high
  assign raw = {i_pins.port1_attach_in, i_pins.port1_orientation_in,
                i_pins.mux_attach_sel_a, i_pins.mux_attach_sel_b} ^
               {(typec_attach_pkg::ATTACH_W + 3){pol}};

  attach_filter #(
    .WIDTH(typec_attach_pkg::ATTACH_W + 3),
    .STABLE(FILT)
  ) u_filter (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_level(raw),
    .o_level(flt)
  );

  logic ext_att;
  logic m1_att;
  logic m1_flip;
  logic sel_a;
  logic sel_b;
  assign ext_att = |flt[typec_attach_pkg::ATTACH_W+2:3];
  assign m1_att = flt[typec_attach_pkg::ATTACH_W+2];
  assign m1_flip = flt[2];
  assign sel_a = flt[1];
  assign sel_b = flt[0];

  // strap capture once, after reset release
  always_comb begin
    next_cfg = cfg;
    next_pol = pol;
    next_strap_done = 1'b1;
    if (!strap_done) begin
      next_pol = i_attach_polarity_strap;
      if (i_external_mux_sel) begin
        next_cfg = typec_attach_pkg::CFG_EXT_MUX;
      end else if (i_internal_mux_mode_sel) begin
        next_cfg = typec_attach_pkg::CFG_MODE_TWO;
      end else begin
        next_cfg = typec_attach_pkg::CFG_MODE_ONE;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg <= typec_attach_pkg::CFG_MODE_ONE;
      pol <= 1'b0;
      strap_done <= 1'b0;
    end else begin
      cfg <= next_cfg;
      pol <= next_pol;
      strap_done <= next_strap_done;
    end
  end

  // lane 0 serves normal orientation, lane 1 flipped
  always_comb begin
    next_ctl = typec_attach_pkg::PHY_CTL_RESET;
    if (strap_done) begin
      case (cfg)
        typec_attach_pkg::CFG_EXT_MUX: begin
          next_ctl.attached = ext_att;
          next_ctl.phy_clk_en = ext_att;
          next_ctl.phy_lane_en = {1'b0, ext_att};
        end
        typec_attach_pkg::CFG_MODE_ONE: begin
          next_ctl.attached = m1_att;
          next_ctl.flipped = m1_att & m1_flip;
          next_ctl.phy_clk_en = m1_att;
          next_ctl.phy_lane_en = {m1_att & m1_flip,
                                  m1_att & ~m1_flip};
        end
        typec_attach_pkg::CFG_MODE_TWO: begin
          // one of A/B asserted names the orientation; both or none: idle
          next_ctl.attached = sel_a ^ sel_b;
          next_ctl.flipped = sel_b & ~sel_a;
          next_ctl.phy_clk_en = sel_a ^ sel_b;
          next_ctl.phy_lane_en = {sel_b & ~sel_a, sel_a & ~sel_b};
        end
        default: begin
          next_ctl = typec_attach_pkg::PHY_CTL_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctl <= typec_attach_pkg::PHY_CTL_RESET;
      o_cfg <= 2'(typec_attach_pkg::CFG_MODE_ONE);
    end else begin
      ctl <= next_ctl;
      o_cfg <= cfg;
    end
  end

  assign o_phy_clk_en = ctl.phy_clk_en;
  assign o_phy_lane_en = ctl.phy_lane_en;
  assign o_attached = ctl.attached;
  assign o_flipped = ctl.flipped;

  sequence s_detach;
    !o_attached;
  endsequence

  AST_NO_ATTACH_IDLE: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    s_detach |-> (!o_phy_clk_en && o_phy_lane_en == '0))
    else $error("phy active without attach");

  AST_ONE_LANE: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    cfg != typec_attach_pkg::CFG_EXT_MUX |-> !(&o_phy_lane_en))
    else $error("both lanes enabled");

  AST_EXT_CLK: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (strap_done && cfg == typec_attach_pkg::CFG_EXT_MUX) |=>
    (o_phy_clk_en == $past(ext_att)))
    else $error("external mux clock gate mismatch");

  AST_MODE_TWO_STRAP: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (!strap_done && !i_external_mux_sel && i_internal_mux_mode_sel) |=>
    cfg == typec_attach_pkg::CFG_MODE_TWO)
    else $error("mode two not selected");

  AST_MODE_ONE_STRAP: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (!strap_done && !i_external_mux_sel && !i_internal_mux_mode_sel) |=>
    cfg == typec_attach_pkg::CFG_MODE_ONE)
    else $error("mode one not selected");

  AST_M1_ORIENT: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (strap_done && cfg == typec_attach_pkg::CFG_MODE_ONE && m1_att) |=>
    (o_flipped == $past(m1_flip) && o_attached))
    else $error("mode one orientation wrong");

  AST_M2_DECODE: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (strap_done && cfg == typec_attach_pkg::CFG_MODE_TWO) |=>
    (o_attached == ($past(sel_a) ^ $past(sel_b))))
    else $error("mode two attach wrong");

  AST_POL_HELD: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    strap_done |=> $stable(pol))
    else $error("polarity changed after capture");

  AST_CFG_LEGAL: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    cfg != 2'b11)
    else $error("illegal configuration");

  AST_EXT_STRAP: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (!strap_done && i_external_mux_sel) |=>
    cfg == typec_attach_pkg::CFG_EXT_MUX)
    else $error("external mux not selected");

  AST_CFG_HELD: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    strap_done |=> $stable(cfg))
    else $error("configuration changed after capture");

  AST_CFG_OUT: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    strap_done |=> (o_cfg == $past(cfg)))
    else $error("reported configuration mismatch");

  AST_EXT_LANE: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (strap_done && cfg == typec_attach_pkg::CFG_EXT_MUX) |=>
    (o_phy_lane_en == {1'b0, $past(ext_att)} && !o_flipped))
    else $error("external mux lane enable mismatch");

  AST_M1_IDLE: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (strap_done && cfg == typec_attach_pkg::CFG_MODE_ONE && !m1_att) |=>
    (!o_attached && !o_phy_clk_en))
    else $error("mode one active without attach");

  AST_M2_LANE: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (strap_done && cfg == typec_attach_pkg::CFG_MODE_TWO) |=>
    (o_phy_lane_en == {$past(sel_b) & ~$past(sel_a),
                       $past(sel_a) & ~$past(sel_b)}))
    else $error("mode two lane enable mismatch");

endmodule : typec_attach_phy_control
`default_nettype wire

// ==== verification/typec_ctrl_model.sv ====
// Purpose: model of the external Type-C controller driving the attach pins
// Assumes: the bench gives the attach state as active-high levels
// Notes: the levels are inverted when the polarity strap says active low
`timescale 1ns/1ps
`default_nettype none
module typec_ctrl_model (
  input wire logic i_core_clk,
  input wire logic i_pol,
  input wire typec_attach_pkg::attach_pins_t i_lvl,
  output var typec_attach_pkg::attach_pins_t o_pins
);
  // pins change just after a clock edge, as a synchronous controller would
  always_ff @(posedge i_core_clk) begin
    o_pins <= i_lvl ^ {6{i_pol}};
  end
endmodule : typec_ctrl_model
`default_nettype wire

// ==== verification/tb.sv ====
// Purpose: self-checking bench for the attach decoder
// Assumes: straps are taken once after each reset release
// Notes: every configuration and polarity is run with random pin levels
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module tb;
  logic i_core_clk, i_rst_n, ext_sel, mode_sel, pol_strap, pol;
  typec_attach_pkg::attach_pins_t lvl, pins;
  logic o_phy_clk_en, o_attached, o_flipped;
  logic [1:0] o_phy_lane_en, o_cfg;
  logic [6:0] expq[$];
  logic [6:0] e;
  int n_errors = 0;
  int comparisons = 0;
  event chk_ev;

  typec_attach_phy_control #(.FILT(2)) u_typec_attach_phy_control (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_external_mux_sel(ext_sel),
    .i_internal_mux_mode_sel(mode_sel),
    .i_attach_polarity_strap(pol_strap),
    .i_pins(pins),
    .o_phy_clk_en(o_phy_clk_en),
    .o_phy_lane_en(o_phy_lane_en),
    .o_attached(o_attached),
    .o_flipped(o_flipped),
    .o_cfg(o_cfg)
  );

  typec_ctrl_model u_typec_ctrl_model (
    .i_core_clk(i_core_clk),
    .i_pol(pol),
    .i_lvl(lvl),
    .o_pins(pins)
  );

  initial begin
    i_core_clk = 1'b0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end

  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  // expected {clk_en, lanes, attached, flipped, cfg} from active-high levels
  function automatic logic [6:0] model(logic [1:0] cfg,
                                       typec_attach_pkg::attach_pins_t l);
    logic att, fl;
    case (cfg)
      2'b00: begin
        att = |l.port1_attach_in;
        fl = 1'b0;
      end
      2'b01: begin
        att = l.port1_attach_in[2];
        fl = l.port1_orientation_in;
      end
      default: begin
        att = l.mux_attach_sel_a ^ l.mux_attach_sel_b;
        fl = l.mux_attach_sel_b & ~l.mux_attach_sel_a;
      end
    endcase
    fl = fl & att;
    return {att, att ? {fl, ~fl} : 2'b00, att, fl, cfg};
  endfunction : model

  initial forever begin
    @(chk_ev);
    e = expq.pop_front();
    `CHK("phy_clk_en", e[6], o_phy_clk_en)
    `CHK("phy_lane_en", e[5:4], o_phy_lane_en)
    `CHK("attached", e[3], o_attached)
    `CHK("flipped", e[2], o_flipped)
    `CHK("cfg", e[1:0], o_cfg)
  end

  initial begin
    #20000;
    n_errors++;
    tally_and_finish();
  end

  initial begin
    logic [1:0] cfg;
    void'($urandom(33492));
    i_rst_n = 1'b0;
    ext_sel = 1'b0;
    mode_sel = 1'b0;
    pol_strap = 1'b0;
    pol = 1'b0;
    lvl = '0;
    for (int k = 0; k < 6; k++) begin
      cfg = 2'(k % 3);
      @(posedge i_core_clk);
      #1;
      i_rst_n = 1'b0;
      ext_sel = (cfg == 2'b00);
      mode_sel = (cfg == 2'b10);
      pol = (k >= 3);
      pol_strap = pol;
      lvl = '0;
      repeat (5) @(posedge i_core_clk);
      #1;
      expq.push_back(7'h01);
      ->chk_ev;
      i_rst_n = 1'b1;
      @(posedge i_core_clk);
      #1;
      // late strap changes must not move the captured configuration
      ext_sel = 1'($urandom);
      mode_sel = 1'($urandom);
      pol_strap = 1'($urandom);
      for (int t = 0; t < 8; t++) begin
        @(posedge i_core_clk);
        #1;
        lvl = (t == 0) ? 6'h00 : 6'($urandom);
        repeat (8) @(posedge i_core_clk);
        #1;
        expq.push_back(model(cfg, lvl));
        ->chk_ev;
      end
    end
    @(posedge i_core_clk);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
